// >>> rtl/gpr_pkg.sv
// shared constants, types and remap table for the five-port pin bank
`default_nettype none
package gpr_pkg;
  // ---------------------------------------------------------------
  // geometry and address map
  // ---------------------------------------------------------------
  localparam int          GPR_PORTS   = 5;
  localparam int          GPR_PINS    = 16;
  localparam int          GPR_AF      = 14;
  localparam int          SLOT_W      = 4;
  localparam int          SLOTS_REG   = 8;
  localparam int          PORT_LSB    = 10;
  localparam int          PORT_W      = 3;
  localparam int          OFF_W       = 10;
  localparam int          HALF_W      = 16;
  localparam logic [31:0] GPR_BASE    = 32'h4001_0800;
  localparam logic [31:0] GPR_SPAN    = 32'h0000_1400;
  localparam logic [9:0]  OFF_CFG_LO  = 10'h000;
  localparam logic [9:0]  OFF_CFG_HI  = 10'h004;
  localparam logic [9:0]  OFF_IN      = 10'h008;
  localparam logic [9:0]  OFF_LATCH   = 10'h00c;
  localparam logic [9:0]  OFF_BSC     = 10'h010;
  // ---------------------------------------------------------------
  // reset values and field codes
  // ---------------------------------------------------------------
  localparam logic [31:0] CFG_RESET   = 32'h4444_4444;
  localparam logic [15:0] LATCH_RESET = 16'h0000;
  localparam logic [1:0]  MODE_INPUT  = 2'h0;
  localparam logic [1:0]  CFG_ANALOG  = 2'h0;
  localparam logic [1:0]  CFG_FLOAT   = 2'h1;
  localparam logic [1:0]  CFG_PULL    = 2'h2;
  localparam logic [1:0]  CFG_AF_OD   = 2'h3;
  localparam int          CFG_OD_BIT  = 0;
  localparam int          CFG_AF_BIT  = 1;
  localparam logic [1:0]  CAN0_NONE   = 2'h0;
  localparam logic [1:0]  CAN0_PART   = 2'h2;
  localparam logic [1:0]  CAN0_FULL   = 2'h3;
  localparam logic [2:0]  PA = 3'h0, PB = 3'h1, PC = 3'h2, PD = 3'h3;
  localparam int          PORT_C      = 2;
  localparam int          PORT_D      = 3;
  localparam logic [15:0] LS_OSC_MASK = 16'hc000;
  localparam logic [15:0] HS_OSC_MASK = 16'h0003;
  localparam logic [3:0]  AF_I2C_SCL  = 4'h0;
  localparam logic        AF_IDLE_LVL = 1'b1;

  typedef enum logic [1:0] {GPR_IDLE = 2'b01, GPR_ACK = 2'b10} gpr_bus_st_t;

  typedef struct packed {
    logic       first_i2c_remap_select;
    logic       first_spi_remap_select;
    logic       third_spi_remap_select;
    logic [1:0] first_can_remap_select;
    logic       second_can_remap_select;
  } gpr_remap_t;

  typedef struct packed {
    logic [15:0]      out;
    logic [15:0]      oe;
    logic [15:0]      ie;
    logic [15:0]      pull_en;
    logic [15:0]      pull_up;
    logic [15:0][1:0] speed;
  } gpr_pad_t;

  typedef struct packed {
    logic       valid;
    logic [2:0] port;
    logic [3:0] pin;
  } gpr_loc_t;

  function automatic gpr_loc_t loc(input logic [2:0] p, input logic [3:0] n);
    return '{1'b1, p, n};
  endfunction : loc

  // af signal order: i2c scl,sda | spi0 nss,sck,miso,mosi | spi2 same | can0 rx,tx | can1 rx,tx
  function automatic gpr_loc_t gpr_af_loc(input logic [3:0] s, input gpr_remap_t r);
    logic i, a, b, c;
    logic [1:0] k;
    i = r.first_i2c_remap_select;
    a = r.first_spi_remap_select;
    b = r.third_spi_remap_select;
    c = r.second_can_remap_select;
    k = r.first_can_remap_select;
    case (s)
      4'h0: return i ? loc(PB, 4'h8) : loc(PB, 4'h6);
      4'h1: return i ? loc(PB, 4'h9) : loc(PB, 4'h7);
      4'h2: return a ? loc(PA, 4'hf) : loc(PA, 4'h4);
      4'h3: return a ? loc(PB, 4'h3) : loc(PA, 4'h5);
      4'h4: return a ? loc(PB, 4'h4) : loc(PA, 4'h6);
      4'h5: return a ? loc(PB, 4'h5) : loc(PA, 4'h7);
      4'h6: return b ? loc(PA, 4'h4) : loc(PA, 4'hf);
      4'h7: return b ? loc(PC, 4'ha) : loc(PB, 4'h3);
      4'h8: return b ? loc(PC, 4'hb) : loc(PB, 4'h4);
      4'h9: return b ? loc(PC, 4'hc) : loc(PB, 4'h5);
      4'ha: return k == CAN0_NONE ? loc(PA, 4'hb) : k == CAN0_PART ? loc(PB, 4'h8) :
                   k == CAN0_FULL ? loc(PD, 4'h0) : '0;
      4'hb: return k == CAN0_NONE ? loc(PA, 4'hc) : k == CAN0_PART ? loc(PB, 4'h9) :
                   k == CAN0_FULL ? loc(PD, 4'h1) : '0;
      4'hc: return c ? loc(PB, 4'h5) : loc(PB, 4'hc);
      4'hd: return c ? loc(PB, 4'h6) : loc(PB, 4'hd);
      default: return '0;
    endcase
  endfunction : gpr_af_loc
endpackage : gpr_pkg
`default_nettype wire

// >>> rtl/gpr_port_bank.sv
// five sixteen-pin general purpose ports with peripheral pin remapping
`default_nettype none
// Functional notes
// RULE_01 - pins 0-7: 4-bit slots, mode low, config high
// RULE_02 - pins 8-15 same layout at offset 0x04
// RULE_03 - both config registers reset to 0x44444444
// RULE_04 - mode 00 input, else output speed grade
// RULE_05 - input config: analog, floating, pull, reserved
// RULE_06 - output config: gpio/peripheral, push-pull/open-drain
// RULE_07 - input level register at 0x08, pin levels
// RULE_08 - input level upper half reads zero
// RULE_09 - output latch at 0x0C, resets to zero
// RULE_10 - set half of 0x10 sets latch bits
// RULE_11 - clear half of 0x10 clears latch bits
// RULE_12 - software uses only full word accesses
// RULE_13 - five ports, 0x400 apart from 0x40010800
// RULE_14 - low-speed oscillator takes port C 14/15
// RULE_15 - power loss forces port C 14/15 analog
// RULE_16 - high-speed oscillator takes port D 0/1
// RULE_17 - i2c remap: PB6/PB7 or PB8/PB9
// RULE_18 - first spi remap: PA4-7 or PA15,PB3-5
// RULE_19 - third spi remap: PA15,PB3-5 or PA4,PC10-12
// RULE_20 - first can remap: PA11/12, PB8/9, PD0/1
// RULE_21 - second can remap: PB12/13 or PB5/6
// RULE_22 - latch reads written value, input sampled each cycle
// RULE_23 - analog pin reads 0, no drive, no input
// RULE_24 - simultaneous set and clear: set wins
// RULE_25 - reserved bits ignore writes, read zero
module gpr_port_bank
  import gpr_pkg::*;
(
  input  wire logic                             core_clk,
  input  wire logic                             rst,
  input  wire logic                             psel,
  input  wire logic                             penable,
  input  wire logic                             pwrite,
  input  wire logic [31:0]                      paddr,
  input  wire logic [31:0]                      pwdata,
  output var  logic [31:0]                      prdata_q,
  output var  logic                             pready_q,
  output var  logic                             pslverr_q,
  input  wire logic [GPR_PORTS-1:0][GPR_PINS-1:0] pin_in,
  output var  gpr_pad_t [GPR_PORTS-1:0]         pad_q,
  input  wire gpr_remap_t                       remap,
  input  wire logic                             low_speed_crystal_osc_en,
  input  wire logic                             high_speed_crystal_osc_en,
  input  wire logic                             core_domain_off,
  input  wire logic                             battery_supply_active,
  input  wire logic [GPR_AF-1:0]                af_out,
  input  wire logic [GPR_AF-1:0]                af_oe,
  output var  logic [GPR_AF-1:0]                af_in_q
);
  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [31:0]       cfg_lo_q [GPR_PORTS];
  logic [31:0]       cfg_hi_q [GPR_PORTS];
  logic [15:0]       latch_q  [GPR_PORTS];
  logic [15:0]       in_q     [GPR_PORTS];
  logic [15:0]       blind    [GPR_PORTS];
  logic [15:0]       af_val   [GPR_PORTS];
  logic [15:0]       af_en    [GPR_PORTS];
  gpr_pad_t          pad_d    [GPR_PORTS];
  gpr_bus_st_t       st_q;
  logic [31:0]       rel;
  logic [PORT_W-1:0] sel_port;
  logic [OFF_W-1:0]  sel_off;
  logic              reg_hit;
  logic              wr_fire;
  logic [31:0]       rd_data;

  function automatic logic [3:0] slot_of(input logic [31:0] lo, input logic [31:0] hi,
                                         input int n);
    logic [31:0] w;
    w = (n < SLOTS_REG) ? lo : hi;
    return w[(n % SLOTS_REG)*SLOT_W +: SLOT_W];
  endfunction : slot_of

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  always_comb begin
    rel      = paddr - GPR_BASE;
    sel_port = rel[PORT_LSB +: PORT_W];
    sel_off  = rel[OFF_W-1:0];
    reg_hit  = 1'b0;
    rd_data  = '0;
    if (paddr < GPR_BASE || rel >= GPR_SPAN) begin // [RULE_13]
      reg_hit = 1'b0;
    end else if (sel_off == OFF_CFG_LO) begin // [RULE_01]
      reg_hit = 1'b1;
      rd_data = cfg_lo_q[sel_port];
    end else if (sel_off == OFF_CFG_HI) begin // [RULE_02]
      reg_hit = 1'b1;
      rd_data = cfg_hi_q[sel_port];
    end else if (sel_off == OFF_IN) begin // [RULE_07] [RULE_08]
      reg_hit = 1'b1;
      rd_data = {{HALF_W{1'b0}}, in_q[sel_port]};
    end else if (sel_off == OFF_LATCH) begin // [RULE_09] [RULE_22] [RULE_25]
      reg_hit = 1'b1;
      rd_data = {{HALF_W{1'b0}}, latch_q[sel_port]};
    end else if (sel_off == OFF_BSC) begin
      // write-only register reads as zero
      reg_hit = 1'b1;
    end
  end

  // only whole-word accesses exist on this bus, so no lane handling [RULE_12]
  assign wr_fire = (st_q == GPR_ACK) && psel && penable && pwrite && reg_hit;

  // ---------------------------------------------------------------
  // bus handshake: one wait-free access phase, data from a flop
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_q      <= GPR_IDLE;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end else begin
      case (st_q)
        GPR_IDLE: begin
          if (psel && !penable) begin
            st_q      <= GPR_ACK;
            pready_q  <= 1'b1;
            pslverr_q <= !reg_hit;
            prdata_q  <= pwrite ? '0 : rd_data;
          end
        end
        GPR_ACK: begin
          st_q      <= GPR_IDLE;
          pready_q  <= 1'b0;
          pslverr_q <= 1'b0;
        end
        default: begin
          st_q     <= GPR_IDLE;
          pready_q <= 1'b0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    for (int p = 0; p < GPR_PORTS; p++) begin
      if (rst) begin
        cfg_lo_q[p] <= CFG_RESET; // [RULE_03]
        cfg_hi_q[p] <= CFG_RESET;
      end else if (wr_fire && sel_port == PORT_W'(p)) begin
        if (sel_off == OFF_CFG_LO) begin
          cfg_lo_q[p] <= pwdata; // [RULE_01]
        end
        if (sel_off == OFF_CFG_HI) begin
          cfg_hi_q[p] <= pwdata; // [RULE_02]
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // output latch with atomic set/clear
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    for (int p = 0; p < GPR_PORTS; p++) begin
      if (rst) begin
        latch_q[p] <= LATCH_RESET; // [RULE_09]
      end else if (wr_fire && sel_port == PORT_W'(p)) begin
        if (sel_off == OFF_LATCH) begin
          latch_q[p] <= pwdata[HALF_W-1:0]; // [RULE_25]
        end else if (sel_off == OFF_BSC) begin
          // set applied after clear so it wins a double request
          latch_q[p] <= (latch_q[p] & ~pwdata[31:HALF_W]) // [RULE_11]
                        | pwdata[HALF_W-1:0]; // [RULE_10] [RULE_24]
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // input sampling, every cycle
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    for (int p = 0; p < GPR_PORTS; p++) begin
      if (rst) begin
        in_q[p] <= '0;
      end else begin
        in_q[p] <= pin_in[p] & ~blind[p]; // [RULE_07] [RULE_22] [RULE_23]
      end
    end
  end

  // ---------------------------------------------------------------
  // peripheral routing
  // ---------------------------------------------------------------
  // overlapping selections (e.g. both spi units on one pin) resolve to the
  // higher signal index; software must avoid them
  always_comb begin
    gpr_loc_t l;
    l = '0;
    for (int p = 0; p < GPR_PORTS; p++) begin
      af_val[p] = '0;
      af_en[p]  = '0;
    end
    for (int s = 0; s < GPR_AF; s++) begin
      l = gpr_af_loc(4'(s), remap); // [RULE_17] [RULE_18] [RULE_19] [RULE_20] [RULE_21]
      if (l.valid) begin
        af_val[l.port][l.pin] = af_out[s];
        af_en[l.port][l.pin]  = af_oe[s];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    for (int s = 0; s < GPR_AF; s++) begin
      gpr_loc_t l;
      l = gpr_af_loc(4'(s), remap);
      if (rst) begin
        af_in_q[s] <= AF_IDLE_LVL;
      end else begin
        af_in_q[s] <= l.valid ? pin_in[l.port][l.pin] : AF_IDLE_LVL; // [RULE_17]
      end
    end
  end

  // ---------------------------------------------------------------
  // pad control
  // ---------------------------------------------------------------
  always_comb begin
    logic [3:0]  slot;
    logic [1:0]  md;
    logic [1:0]  cf;
    logic [15:0] ovr;
    logic        ana;
    logic        src;
    logic        en;
    slot = '0;
    md   = '0;
    cf   = '0;
    ovr  = '0;
    ana  = 1'b0;
    src  = 1'b0;
    en   = 1'b0;
    for (int p = 0; p < GPR_PORTS; p++) begin
      pad_d[p] = '0;
      blind[p] = '0;
      ovr      = '0;
      if (p == PORT_C && (low_speed_crystal_osc_en || core_domain_off
                          || battery_supply_active)) begin
        ovr = LS_OSC_MASK; // [RULE_14] [RULE_15]
      end
      if (p == PORT_D && high_speed_crystal_osc_en) begin
        ovr = HS_OSC_MASK; // [RULE_16]
      end
      for (int n = 0; n < GPR_PINS; n++) begin
        slot = slot_of(cfg_lo_q[p], cfg_hi_q[p], n); // [RULE_01] [RULE_02]
        md   = slot[1:0];
        cf   = slot[3:2];
        ana  = ovr[n] || (md == MODE_INPUT && cf == CFG_ANALOG); // [RULE_05] [RULE_23]
        src  = cf[CFG_AF_BIT] ? af_val[p][n] : latch_q[p][n]; // [RULE_06]
        en   = cf[CFG_AF_BIT] ? af_en[p][n] : 1'b1;
        blind[p][n]  = ana;
        pad_d[p].ie[n] = !ana;
        if (md != MODE_INPUT && !ovr[n]) begin // [RULE_04]
          pad_d[p].speed[n] = md;
          if (cf[CFG_OD_BIT]) begin
            pad_d[p].out[n] = 1'b0;
            pad_d[p].oe[n]  = en && !src;
          end else begin
            pad_d[p].out[n] = src;
            pad_d[p].oe[n]  = en;
          end
        end else if (md == MODE_INPUT && cf == CFG_PULL && !ovr[n]) begin // [RULE_05]
          // pull direction follows the latch bit
          pad_d[p].pull_en[n] = 1'b1;
          pad_d[p].pull_up[n] = latch_q[p][n];
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    for (int p = 0; p < GPR_PORTS; p++) begin
      if (rst) begin
        pad_q[p] <= '0;
      end else begin
        pad_q[p] <= pad_d[p];
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  AST_CFG_RESET: assert property (@(posedge core_clk) // [RULE_03]
    $fell(rst) |-> cfg_lo_q[PORT_C] == CFG_RESET && cfg_hi_q[PORT_D] == CFG_RESET)
    else $error("config register not at reset value");
  AST_SET_BITS: assert property (@(posedge core_clk) disable iff (rst) // [RULE_10]
    wr_fire && sel_port == PB && sel_off == OFF_BSC
    |=> (latch_q[PB] & $past(pwdata[HALF_W-1:0])) == $past(pwdata[HALF_W-1:0]))
    else $error("set request did not set latch");
  AST_CLR_BITS: assert property (@(posedge core_clk) disable iff (rst) // [RULE_11]
    wr_fire && sel_port == PB && sel_off == OFF_BSC
    |=> (latch_q[PB] & $past(pwdata[31:HALF_W] & ~pwdata[HALF_W-1:0])) == '0)
    else $error("clear request did not clear latch");
  AST_UNTOUCHED: assert property (@(posedge core_clk) disable iff (rst) // [RULE_10] [RULE_11]
    wr_fire && sel_port == PB && sel_off == OFF_BSC
    |=> ((latch_q[PB] ^ $past(latch_q[PB])) & ~$past(pwdata[31:HALF_W] | pwdata[HALF_W-1:0]))
        == '0)
    else $error("latch bit changed without request");
  AST_INPUT_SAMPLE: assert property (@(posedge core_clk) disable iff (rst) // [RULE_22]
    !(low_speed_crystal_osc_en || core_domain_off || battery_supply_active)
    && cfg_hi_q[PORT_C][31:28] != '0 ##1 !rst
    |-> in_q[PORT_C][15] == $past(pin_in[PORT_C][15]))
    else $error("input level not sampled");
  AST_ANALOG_ZERO: assert property (@(posedge core_clk) disable iff (rst) // [RULE_23]
    cfg_lo_q[PB][19:16] == '0 |=> !in_q[PB][4] && !pad_q[PB].oe[4] && !pad_q[PB].ie[4])
    else $error("analog pin not isolated");
  AST_READ_UPPER: assert property (@(posedge core_clk) disable iff (rst) // [RULE_08]
    st_q == GPR_IDLE && psel && !penable && !pwrite && reg_hit && sel_off == OFF_IN
    |=> pready_q && prdata_q[31:HALF_W] == '0)
    else $error("input level upper half not zero");
  AST_LS_OSC: assert property (@(posedge core_clk) disable iff (rst) // [RULE_14] [RULE_15]
    low_speed_crystal_osc_en || core_domain_off || battery_supply_active
    |=> pad_q[PORT_C].oe[15:14] == '0 && in_q[PORT_C][15:14] == '0)
    else $error("low-speed oscillator pins not released");
  AST_HS_OSC: assert property (@(posedge core_clk) disable iff (rst) // [RULE_16]
    high_speed_crystal_osc_en |=> pad_q[PORT_D].oe[1:0] == '0)
    else $error("high-speed oscillator pins still driven");
  AST_OPEN_DRAIN: assert property (@(posedge core_clk) disable iff (rst) // [RULE_06]
    cfg_lo_q[PB][7:4] == {CFG_FLOAT, 2'h3}
    |=> !pad_q[PB].out[1] && pad_q[PB].oe[1] == !$past(latch_q[PB][1]))
    else $error("open-drain drive wrong");
  AST_PUSH_PULL: assert property (@(posedge core_clk) disable iff (rst) // [RULE_04]
    cfg_lo_q[PB][3:2] == CFG_ANALOG && cfg_lo_q[PB][1:0] != MODE_INPUT
    |=> pad_q[PB].oe[0] && pad_q[PB].out[0] == $past(latch_q[PB][0])
        && pad_q[PB].speed[0] == $past(cfg_lo_q[PB][1:0]))
    else $error("push-pull drive wrong");
  AST_I2C_REMAP: assert property (@(posedge core_clk) disable iff (rst) // [RULE_17]
    remap.first_i2c_remap_select |=> af_in_q[AF_I2C_SCL] == $past(pin_in[PB][8]))
    else $error("i2c clock not routed to remapped pin");
endmodule : gpr_port_bank
`default_nettype wire

// >>> verification/gpr_pin_model.sv
// board side of the pin bank: resolves each pad against external drivers and pulls
`default_nettype none
module gpr_pin_model
  import gpr_pkg::*;
(
  input  wire logic                               core_clk,
  input  wire gpr_pad_t [GPR_PORTS-1:0]           pad,
  input  wire logic [GPR_PORTS-1:0][GPR_PINS-1:0] ext_en,
  input  wire logic [GPR_PORTS-1:0][GPR_PINS-1:0] ext_val,
  output var  logic [GPR_PORTS-1:0][GPR_PINS-1:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [GPR_PORTS-1:0][GPR_PINS-1:0] float_q = '0;
  // an undriven pin wanders every cycle so a stale level never passes for a real one
  always_ff @(posedge core_clk) begin
    float_q <= ~pin_in;
  end
  always_comb begin
    for (int p = 0; p < GPR_PORTS; p++) begin
      for (int n = 0; n < GPR_PINS; n++) begin
        if (pad[p].oe[n]) begin
          pin_in[p][n] = pad[p].out[n];
        end else if (ext_en[p][n]) begin
          pin_in[p][n] = ext_val[p][n];
        end else if (pad[p].pull_en[n]) begin
          pin_in[p][n] = pad[p].pull_up[n];
        end else begin
          pin_in[p][n] = float_q[p][n];
        end
      end
    end
  end
endmodule : gpr_pin_model
`default_nettype wire

// >>> verification/test_gpr_port_bank.sv
// self-checking bench for the five-port pin bank
`default_nettype none
module test_gpr_port_bank
  import gpr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = '0, pwdata = '0, prdata_q;
  logic pready_q, pslverr_q;
  logic [GPR_PORTS-1:0][GPR_PINS-1:0] pin_in, ext_en = '0, ext_val = '0;
  gpr_pad_t [GPR_PORTS-1:0] pad_q;
  gpr_remap_t remap = '0;
  logic low_speed_crystal_osc_en = 1'b0, high_speed_crystal_osc_en = 1'b0;
  logic core_domain_off = 1'b0, battery_supply_active = 1'b0;
  logic [GPR_AF-1:0] af_out = '0, af_oe = '0, af_in_q;
  int num_errors = 0, n_tests = 0;
  logic [7:0] nr [14] = '{8'h16, 8'h17, 8'h04, 8'h05, 8'h06, 8'h07, 8'h0f,
                          8'h13, 8'h14, 8'h15, 8'h0b, 8'h0c, 8'h1c, 8'h1d};
  logic [7:0] rm [14] = '{8'h18, 8'h19, 8'h0f, 8'h13, 8'h14, 8'h15, 8'h04,
                          8'h2a, 8'h2b, 8'h2c, 8'h30, 8'h31, 8'h15, 8'h16};
  always #50 core_clk = ~core_clk;
  gpr_port_bank u_gpr_port_bank (.core_clk(core_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q), .pin_in(pin_in),
    .pad_q(pad_q), .remap(remap), .low_speed_crystal_osc_en(low_speed_crystal_osc_en),
    .high_speed_crystal_osc_en(high_speed_crystal_osc_en),
    .core_domain_off(core_domain_off), .battery_supply_active(battery_supply_active),
    .af_out(af_out), .af_oe(af_oe), .af_in_q(af_in_q));
  gpr_pin_model u_gpr_pin_model (.core_clk(core_clk), .pad(pad_q), .ext_en(ext_en),
    .ext_val(ext_val), .pin_in(pin_in));
  // ---------------------------------------------------------------
  // bus cycles and comparisons
  // ---------------------------------------------------------------
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // whole words only, so every access drives all 32 data bits
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int k;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    for (k = 0; k < 8 && pready_q !== 1'b1; k++) @(posedge core_clk);
    if (k == 8) chk(32'h0, 32'h1);
    r = prdata_q;
    e = pslverr_q;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : bus
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    bus(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [31:0] x, input logic [31:0] m,
                    input logic ex);
    logic [31:0] r;
    logic e;
    bus(1'b0, a, 32'h0, r, e);
    chk(r & m, x);
    chk(32'(e), 32'(ex));
  endtask : rd
  function automatic logic [31:0] pa(input int n, input logic [9:0] off);
    return GPR_BASE + 32'(n) * 32'h400 + {22'h0, off};
  endfunction : pa
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    #1_000_000;
    num_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    print_verdict();
  end
  initial begin
    logic [7:0] loc;
    logic [1:0] ec, ed;
    tick(4);
    rst <= 1'b0;
    for (int n = 0; n < GPR_PORTS; n++) begin
      rd(pa(n, OFF_CFG_LO), CFG_RESET, '1, 1'b0);
      rd(pa(n, OFF_CFG_HI), CFG_RESET, '1, 1'b0);
      rd(pa(n, OFF_IN), 32'h0, 32'hffff_0000, 1'b0);
      rd(pa(n, OFF_LATCH), 32'h0, '1, 1'b0);
      rd(pa(n, OFF_BSC), 32'h0, '1, 1'b0);
    end
    $display("test reset values done");
    wr(pa(1, OFF_CFG_LO), 32'h4940_8471);
    wr(pa(1, OFF_CFG_HI), 32'h4444_4442);
    wr(pa(1, OFF_LATCH), 32'hffff_0049);
    af_oe <= 14'h0001;
    ext_en[1] <= 16'h0010;
    ext_val[1] <= 16'h0010;
    rd(pa(1, OFF_CFG_LO), 32'h4940_8471, '1, 1'b0);
    rd(pa(1, OFF_CFG_HI), 32'h4444_4442, '1, 1'b0);
    rd(pa(1, OFF_LATCH), 32'h0000_0049, '1, 1'b0);
    chk(32'(pad_q[1].oe), 32'h0143);
    chk(32'(pad_q[1].out), 32'h0001);
    chk(32'({pad_q[1].speed[1], pad_q[1].speed[0]}), 32'hd);
    chk(32'({pad_q[1].pull_en[3], pad_q[1].pull_up[3], pad_q[1].ie[4]}), 32'h6);
    rd(pa(1, OFF_IN), 32'h0000_0009, 32'hffff_005b, 1'b0);
    wr(pa(1, OFF_BSC), 32'h0000_0002);
    tick(2);
    chk(32'(pad_q[1].oe[1]), 32'h0);
    wr(pa(1, OFF_BSC), 32'h004b_0030);
    rd(pa(1, OFF_LATCH), 32'h0000_0030, '1, 1'b0);
    wr(pa(1, OFF_BSC), 32'h0011_0001);
    rd(pa(1, OFF_LATCH), 32'h0000_0021, '1, 1'b0);
    $display("test config and latch done");
    wr(pa(4, OFF_LATCH), 32'h0000_1234);
    rd(pa(3, OFF_LATCH), 32'h0, '1, 1'b0);
    rd(pa(4, OFF_LATCH), 32'h0000_1234, '1, 1'b0);
    rd(pa(0, 10'h014), 32'h0, '1, 1'b1);
    rd(pa(5, OFF_CFG_LO), 32'h0, '1, 1'b1);
    rd(32'h4001_07fc, 32'h0, '1, 1'b1);
    $display("test address map done");
    wr(pa(2, OFF_CFG_HI), 32'h1144_4444);
    wr(pa(2, OFF_LATCH), 32'h0000_c000);
    wr(pa(3, OFF_CFG_LO), 32'h4444_4411);
    wr(pa(3, OFF_LATCH), 32'h0000_0003);
    ext_en[2] <= 16'hc000;
    ext_val[2] <= 16'hc000;
    ext_en[3] <= 16'h0003;
    ext_val[3] <= 16'h0003;
    for (int c = 0; c < 5; c++) begin
      {low_speed_crystal_osc_en, core_domain_off, battery_supply_active,
       high_speed_crystal_osc_en} <= 4'b1000 >> c;
      tick(3);
      ec = c < 3 ? 2'b00 : 2'b11;
      ed = c == 3 ? 2'b00 : 2'b11;
      chk(32'(pad_q[2].oe[15:14]), 32'(ec));
      chk(32'(pad_q[3].oe[1:0]), 32'(ed));
      rd(pa(2, OFF_IN), {16'h0, ec, 14'h0}, 32'h0000_c000, 1'b0);
      rd(pa(3, OFF_IN), {30'h0, ed}, 32'h0000_0003, 1'b0);
    end
    $display("test oscillator pins done");
    rst <= 1'b1;
    tick(2);
    rst <= 1'b0;
    ext_en <= '1;
    ext_val <= '0;
    rd(pa(1, OFF_CFG_LO), CFG_RESET, '1, 1'b0);
    for (int s = 0; s < GPR_AF; s++) begin
      for (int m = 0; m < 3; m++) begin
        remap <= gpr_remap_t'(m == 1 ? 6'h3f : m == 2 ? 6'h04 : 6'h00);
        loc = m == 1 ? rm[s] : (m == 2 && s > 9 && s < 12) ? 8'(14 + s) : nr[s];
        ext_val[loc[6:4]][loc[3:0]] <= 1'b1;
        tick(3);
        chk(32'(af_in_q[s]), 32'h1);
        ext_val <= '0;
        tick(3);
        chk(32'(af_in_q[s]), 32'h0);
      end
    end
    remap <= gpr_remap_t'(6'h02);
    tick(3);
    chk(32'(af_in_q[11:10]), 32'h3);
    $display("test remap done");
    print_verdict();
  end
endmodule : test_gpr_port_bank
`default_nettype wire
